// file: logic/srs_shift_store.sv
// eight-stage shift register feeding an eight-bit storage register
//
// How it works
// - eight shift stages feed an eight-bit storage register.
// - both registers shift or load only on rising edges of their own clocks.
// - shift clear low empties every shift stage, overriding shifting.
// - shift edge loads serial input into stage one, others take predecessor.
// - without a shift edge the shift stages hold.
// - storage clear low empties storage, independent of shift clear.
// - storage edge copies all eight shift stages at once.
// - without a storage edge the storage register holds.
// - cascade output carries the last shift stage for chaining.
// - with tied clocks storage gets the shift contents before that edge.
//
// device clocks arrive as plain levels sampled on i_clk
// a rising edge is a low sample followed by a high sample
// clears are levels, seen at every i_clk edge while low
// a clock edge that meets its own clear low does nothing
// controller holds each clock level and clear for one i_clk at least
// a clock held high across reset release counts as a rise
// tied clocks: storage takes the shift contents from before the edge
// the cascade output lets a second register chain from the last stage
// reset is synchronous and active low; every output reads zero then
// all outputs come from flip-flops, one edge after the state they show
//
// stream side, added on top of the device behaviour
// each accepted storage edge also offers its word on valid/ready
// path is push stage, two-entry buffer and registered output stage
// a word shows three edges after its storage edge on an idle path
// a stalled receiver backs the path up, then further words are dropped
// parallel outputs update even when the stream drops a word
`timescale 1ns/10ps
`default_nettype none
module srs_shift_store #(
   parameter int WIDTH = srs_pkg::WIDTH
) (
   input  wire logic             i_clk,
   input  wire logic             i_resetn,
   // device pins
   input  wire logic             i_serial_in,
   input  wire logic             i_shift_clock,
   input  wire logic             i_shift_clear_n,
   input  wire logic             i_store_clock,
   input  wire logic             i_store_clear_n,
   // parallel and cascade outputs
   output logic      [WIDTH-1:0] o_parallel_out,
   output logic                  o_cascade_out,
   // word stream
   output logic                  o_word_valid,
   output logic      [WIDTH-1:0] o_word_data,
   input  wire logic             i_word_ready,
   output logic                  o_word_dropped
);
   // device state
   logic             shift_clk_prev_reg;
   logic             store_clk_prev_reg;
   logic [WIDTH-1:0] shift_reg;
   logic [WIDTH-1:0] store_reg;
   logic             shift_rise;
   logic             store_rise;

   // stream path
   logic             store_take;
   logic             push_full;
   logic             push_load;
   logic             push_valid_reg;
   logic [WIDTH-1:0] push_data_reg;
   logic             buf_ready;
   logic             buf_valid;
   logic [WIDTH-1:0] buf_data;
   logic             out_free;

   // rise between the previous and the current sample
   // shared by both device clocks
   function automatic logic rise_of(input logic cur, input logic prev);
      return cur && !prev;
   endfunction : rise_of

   // edge detection on the sampled device clocks
   // a rise needs a low sample first, so a clock held high acts once
   assign shift_rise = rise_of(i_shift_clock, shift_clk_prev_reg);
   assign store_rise = rise_of(i_store_clock, store_clk_prev_reg);

   // previous shift clock sample; low after reset, the idle level
   always_ff @(posedge i_clk) begin
      if (!i_resetn) begin
         shift_clk_prev_reg <= 1'b0;
      end else begin
         shift_clk_prev_reg <= i_shift_clock;
      end
   end

   // previous storage clock sample, same scheme
   always_ff @(posedge i_clk) begin
      if (!i_resetn) begin
         store_clk_prev_reg <= 1'b0;
      end else begin
         store_clk_prev_reg <= i_store_clock;
      end
   end

   // shift register; clear wins over any edge
   // stage one is bit zero, so the cascade output sees the first bit first
   always_ff @(posedge i_clk) begin
      if (!i_resetn) begin
         shift_reg <= WIDTH'(srs_pkg::SHIFT_RST);
      end else if (!i_shift_clear_n) begin
         shift_reg <= '0;
      end else if (shift_rise) begin
         shift_reg <= {shift_reg[WIDTH-2:0], i_serial_in};
      end
      // otherwise hold
   end

   // storage register samples the pre-edge shift contents
   // a shift edge in the same cycle lands after this copy
   // clear low wins over a storage edge, apart from the shift clear
   always_ff @(posedge i_clk) begin
      if (!i_resetn) begin
         store_reg <= WIDTH'(srs_pkg::STORE_RST);
      end else if (!i_store_clear_n) begin
         store_reg <= '0;
      end else if (store_rise) begin
         store_reg <= shift_reg;
      end
      // otherwise hold
   end

   // cascade output registered from the last shift stage
   always_ff @(posedge i_clk) begin
      if (!i_resetn) begin
         o_cascade_out <= 1'b0;
      end else begin
         o_cascade_out <= shift_reg[WIDTH-1];
      end
   end

   // parallel outputs registered from the storage register
   always_ff @(posedge i_clk) begin
      if (!i_resetn) begin
         o_parallel_out <= '0;
      end else begin
         o_parallel_out <= store_reg;
      end
   end

   // stream path takes only the storage edges that the clear lets through
   assign store_take = i_store_clear_n && store_rise;
   assign push_full  = push_valid_reg && !buf_ready;
   assign push_load  = store_take && !push_full;
   // output stage frees when empty or taken, and the buffer pops only then,
   // so a word is never shown at the output and still kept in the queue
   assign out_free   = !o_word_valid || i_word_ready;

   // push stage valid; a storage edge loads it, the buffer empties it
   always_ff @(posedge i_clk) begin
      if (!i_resetn) begin
         push_valid_reg <= 1'b0;
      end else if (push_load) begin
         push_valid_reg <= 1'b1;
      end else if (buf_ready) begin
         push_valid_reg <= 1'b0;
      end
   end

   // push stage word, the same shift contents the storage copy takes
   always_ff @(posedge i_clk) begin
      if (!i_resetn) begin
         push_data_reg <= '0;
      end else if (push_load) begin
         push_data_reg <= shift_reg;
      end
   end

   // one-cycle pulse when a storage edge finds the stream path full;
   // storage still updates, only the stream loses the word
   always_ff @(posedge i_clk) begin
      if (!i_resetn) begin
         o_word_dropped <= 1'b0;
      end else begin
         o_word_dropped <= store_take && push_full;
      end
   end

   // two entries absorb the output stage stall without losing a word
   srs_edge_buf #(
      .WIDTH    (WIDTH)
   ) u_buf (
      .i_clk    (i_clk),
      .i_resetn (i_resetn),
      .i_valid  (push_valid_reg),
      .i_data   (push_data_reg),
      .o_ready  (buf_ready),
      .o_valid  (buf_valid),
      .o_data   (buf_data),
      .i_ready  (out_free)
   );

   // output stage valid; loads whenever it is empty or being taken
   // valid and word stay put while the receiver stalls
   always_ff @(posedge i_clk) begin
      if (!i_resetn) begin
         o_word_valid <= 1'b0;
      end else if (out_free) begin
         o_word_valid <= buf_valid;
      end
   end

   // output word keeps the last word passed
   // a popped slot is never shown, since its contents may be stale
   always_ff @(posedge i_clk) begin
      if (!i_resetn) begin
         o_word_data <= '0;
      end else if (out_free && buf_valid) begin
         o_word_data <= buf_data;
      end
   end
endmodule : srs_shift_store
`default_nettype wire

// file: logic/srs_pkg.sv
// constants for the serial-in, parallel-out register with storage
`default_nettype none
package srs_pkg;
   localparam int          WIDTH      = 8;
   localparam int          BUF_DEPTH  = 2;
   localparam logic [7:0]  SHIFT_RST  = 8'h00;
   localparam logic [7:0]  STORE_RST  = 8'h00;
   localparam int          FIRST_BIT  = 0;
endpackage : srs_pkg
`default_nettype wire

// file: logic/srs_edge_buf.sv
// two-entry valid/ready buffer carrying stored words to the receiver
`timescale 1ns/10ps
`default_nettype none
module srs_edge_buf #(
   parameter int WIDTH = 8
) (
   input  wire logic             i_clk,
   input  wire logic             i_resetn,
   input  wire logic             i_valid,
   input  wire logic [WIDTH-1:0] i_data,
   output logic                  o_ready,
   output logic                  o_valid,
   output logic      [WIDTH-1:0] o_data,
   input  wire logic             i_ready
);
   logic [WIDTH-1:0] mem_reg [2];
   logic             wr_ptr_reg;
   logic             rd_ptr_reg;
   logic [1:0]       count_reg;
   logic             push;
   logic             pop;

   assign o_ready = (count_reg != 2'h2);
   assign o_valid = (count_reg != 2'h0);
   assign o_data  = mem_reg[rd_ptr_reg];
   assign push    = i_valid && o_ready;
   assign pop     = o_valid && i_ready;

   always_ff @(posedge i_clk) begin
      if (push) begin
         mem_reg[wr_ptr_reg] <= i_data;
      end
   end

   always_ff @(posedge i_clk) begin
      if (!i_resetn) begin
         wr_ptr_reg <= 1'b0;
         rd_ptr_reg <= 1'b0;
         count_reg  <= 2'h0;
      end else begin
         if (push) begin
            wr_ptr_reg <= ~wr_ptr_reg;
         end
         if (pop) begin
            rd_ptr_reg <= ~rd_ptr_reg;
         end
         count_reg <= count_reg + {1'b0, push} - {1'b0, pop};
      end
   end
endmodule : srs_edge_buf
`default_nettype wire

// file: test/srs_shift_store_sva.sv
// port assertions for the shift and storage register
`timescale 1ns/10ps
`default_nettype none
module srs_chk #(parameter int WIDTH = 8) (
   input wire logic             i_clk,
   input wire logic             i_resetn,
   input wire logic             i_shift_clock,
   input wire logic             i_shift_clear_n,
   input wire logic             i_store_clock,
   input wire logic             i_store_clear_n,
   input wire logic [WIDTH-1:0] o_parallel_out,
   input wire logic             o_cascade_out,
   input wire logic             o_word_valid,
   input wire logic [WIDTH-1:0] o_word_data,
   input wire logic             i_word_ready,
   input wire logic             o_word_dropped
);
   default clocking @(posedge i_clk); endclocking
   default disable iff (!i_resetn);
   sequence s_st_rise;
      i_store_clock && !$past(i_store_clock) && i_store_clear_n;
   endsequence
   sequence s_st_idle;
      (!i_store_clock || $past(i_store_clock)) && i_store_clear_n;
   endsequence
   a_shift_clear: assert property (!i_shift_clear_n |-> ##2 !o_cascade_out)
      else $error("cascade not cleared");
   a_shift_hold: assert property ((!i_shift_clock || $past(i_shift_clock))
      && i_shift_clear_n |-> ##2 $stable(o_cascade_out)) else $error("cascade moved");
   a_store_clear: assert property (!i_store_clear_n |-> ##2 o_parallel_out == '0)
      else $error("storage not cleared");
   a_store_copy: assert property (s_st_rise |-> ##2
      o_parallel_out[WIDTH-1] == $past(o_cascade_out)) else $error("bad copy");
   a_store_hold: assert property (s_st_idle |-> ##2 $stable(o_parallel_out))
      else $error("storage moved");
   a_word_soon: assert property (s_st_rise |-> ##[1:4] o_word_valid)
      else $error("no word");
   a_word_hold: assert property (o_word_valid && !i_word_ready |=>
      o_word_valid && $stable(o_word_data)) else $error("word not held");
   a_drop_pulse: assert property (o_word_dropped |=> !o_word_dropped)
      else $error("drop too long");
endmodule : srs_chk
bind srs_shift_store srs_chk #(.WIDTH(WIDTH)) i_chk (.*);
`default_nettype wire

// file: test/srs_sink.sv
// stream receiver that may stall
`timescale 1ns/10ps
`default_nettype none
module srs_sink (
   input  wire logic i_clk,
   input  wire logic i_stall,
   input  wire logic i_valid,
   output logic      o_ready,
   output int        o_count
);
   int count_reg = 0;
   assign o_ready = !i_stall;
   assign o_count = count_reg;
   always @(posedge i_clk) if (i_valid && o_ready) count_reg <= count_reg + 1;
endmodule : srs_sink
`default_nettype wire

// file: test/srs_shift_store_tb_top.sv
// bench for the shift and storage register
`timescale 1ns/10ps
`default_nettype none
module srs_shift_store_tb_top;
   logic       i_clk = 0, i_resetn = 0, i_serial_in = 0, i_shift_clock = 0, i_store_clock = 0;
   logic       i_shift_clear_n = 1, i_store_clear_n = 1, stall = 0, o_word_valid, i_word_ready;
   logic       o_cascade_out, o_word_dropped;
   logic [7:0] o_parallel_out, o_word_data;
   int         cnt, c0, n_errors = 0, total_checks = 0, nd = 0;
   always #4 i_clk = ~i_clk;
   always @(posedge i_clk) if (o_word_dropped === 1'b1) nd <= nd + 1;
   srs_shift_store i_dut (.*);
   srs_sink i_sink (.i_clk(i_clk), .i_stall(stall), .i_valid(o_word_valid),
      .o_ready(i_word_ready), .o_count(cnt));
   task automatic chk(input string w, input logic [7:0] e, input logic [7:0] g);
      total_checks++;
      if (g !== e) begin
         n_errors++;
         $display("Error %s exp %h got %h", w, e, g);
      end
   endtask : chk
   task automatic tk(input logic s, input logic r, input logic d);
      @(posedge i_clk);
      i_serial_in   <= d;
      i_shift_clock <= s;
      i_store_clock <= r;
      @(posedge i_clk);
      i_shift_clock <= 1'b0;
      i_store_clock <= 1'b0;
   endtask : tk
   task automatic ld(input logic [7:0] b);
      for (int k = 7; k >= 0; k--) tk(1, 0, b[k]);
      repeat (3) @(posedge i_clk);
      #1;
   endtask : ld
   task automatic st(input logic s, input logic [7:0] e);
      tk(s, 1, 1);
      repeat (3) @(posedge i_clk);
      #1;
      chk("parallel", e, o_parallel_out);
      chk("word", e, o_word_data);
   endtask : st
   task automatic t_run;
      ld(8'hA5);
      chk("parallel", 8'h00, o_parallel_out);
      st(0, 8'hA5);
      chk("cascade", 8'h01, {7'h00, o_cascade_out});
      ld(8'h3C);
      st(1, 8'h3C);
      st(0, 8'h79);
      $display("t_run done");
   endtask : t_run
   task automatic t_clr;
      i_shift_clear_n <= 1'b0;
      tk(1, 0, 1);
      i_shift_clear_n <= 1'b1;
      st(0, 8'h00);
      ld(8'hC3);
      i_store_clear_n <= 1'b0;
      tk(0, 1, 0);
      i_store_clear_n <= 1'b1;
      repeat (3) @(posedge i_clk);
      #1;
      chk("parallel", 8'h00, o_parallel_out);
      st(0, 8'hC3);
      $display("t_clr done");
   endtask : t_clr
   task automatic t_stall;
      c0 = cnt;
      stall <= 1'b1;
      repeat (6) st(0, 8'hC3);
      stall <= 1'b0;
      repeat (9) @(posedge i_clk);
      #1;
      chk("dropped", 8'h02, 8'(nd));
      chk("count", 8'(srs_pkg::BUF_DEPTH + 2), 8'(cnt - c0));
      $display("t_stall done");
   endtask : t_stall
   task automatic end_of_test;
      $display("checks %0d errors %0d", total_checks, n_errors);
      if (n_errors == 0 && total_checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask : end_of_test
   initial begin
      repeat (4) @(posedge i_clk);
      i_resetn <= 1'b1;
      t_run();
      t_clr();
      t_stall();
      end_of_test();
   end
   initial begin
      #20000;
      n_errors++;
      end_of_test();
   end
endmodule : srs_shift_store_tb_top
`default_nettype wire
